// ---- hw/eim_pkg.sv ----
// shared constants, types and register map of the energy interval meter
package eim_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ASCALE = 8'h04;
  localparam logic [7:0] REG_QSCALE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_ACT_DEM = 8'h14;
  localparam logic [7:0] REG_ACT_SUP = 8'h18;
  localparam logic [7:0] REG_REA_DEM = 8'h1C;
  localparam logic [7:0] REG_REA_SUP = 8'h20;
  localparam logic [7:0] REG_MINUTE = 8'h24;
  localparam logic [7:0] REG_STATE = 8'h28;

  // ==========================================================
  // control field positions
  localparam int CTRL_PER_LSB = 0;
  localparam int CTRL_SRC_BIT = 4;
  localparam int CTRL_CUM_BIT = 5;
  localparam int CTRL_DIR_BIT = 6;
  localparam int CTRL_MEGA_BIT = 7;

  // status / mask bits
  localparam int ST_REPORT_BIT = 0;
  localparam int ST_PARAM_BIT = 1;
  localparam int ST_OVF_BIT = 2;

  // ==========================================================
  // period encoding
  typedef enum logic [2:0] {
    EIM_PER_OFF = 3'h0,
    EIM_PER_5 = 3'h1,
    EIM_PER_10 = 3'h2,
    EIM_PER_15 = 3'h3,
    EIM_PER_30 = 3'h4,
    EIM_PER_60 = 3'h5
  } eim_period_t;

  // ==========================================================
  // reset values
  localparam eim_period_t PER_RESET = EIM_PER_30;
  localparam logic SRC_RESET = 1'b0;
  localparam logic CUM_RESET = 1'b0;
  localparam logic DIR_RESET = 1'b0;
  localparam logic MEGA_RESET = 1'b0;
  localparam logic [13:0] SCALE_RESET = 14'h0064;
  localparam logic [13:0] SCALE_MIN = 14'h0001;
  localparam logic [13:0] SCALE_MAX = 14'h2710;

  // ==========================================================
  // timing: one real-time clock tick per minute of wall time
  localparam int MINUTE_S = 60;
  localparam int CLK_HZ = 100_000_000;
  localparam longint MINUTE_CYCLES = longint'(MINUTE_S) * longint'(CLK_HZ);
  localparam logic [5:0] MIN_PER_HOUR = 6'h3C;

  // ==========================================================
  typedef struct packed {
    eim_period_t period;
    logic pulse_src;
    logic cumulate;
    logic dir_supply;
    logic mega;
  } eim_cfg_t;

  typedef struct packed {
    logic [31:0] act_dem;
    logic [31:0] act_sup;
    logic [31:0] rea_dem;
    logic [31:0] rea_sup;
  } eim_totals_t;

  typedef struct packed {
    logic act_dem;
    logic act_sup;
    logic rea_dem;
    logic rea_sup;
  } eim_pulses_t;

endpackage

// ---- hw/eim_meter.sv ----
// energy interval metering accumulator with an apb register file
//
// Operation
// RL1 - period off/5/10/15/30/60 min, default 30
// RL2 - source: internal measurement or meter pulses
// RL3 - cumulation flag, default off
// RL4 - cumulation off clears totals after report
// RL5 - direction reference demand or supply, default demand
// RL6 - reference picks direction for in-phase power
// RL7 - positive and negative powers into separate totals
// RL8 - pulse weights 1..10000, default 100
// RL9 - pulse rising edge adds its weight
// RL10 - four totals, kilo or mega scaled
// RL11 - clear input honoured only when cumulating
// RL12 - four pulse inputs used only in pulse mode
// RL13 - report record of four totals each interval
// RL14 - boundaries at period multiples from hour top
// RL15 - parameter change clears totals, drops interval
// RL16 - restart at next boundary, report one period later
// RL17 - period off: no accumulation, no reports
`timescale 1ns/10ps

module eim_meter #(
  parameter longint MINUTE_CYCLES = eim_pkg::MINUTE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] active_power,
  input wire logic [31:0] reactive_power,
  input wire logic power_valid,
  input wire logic total_clear_input,
  input wire logic active_demand_pulse_in,
  input wire logic active_supply_pulse_in,
  input wire logic reactive_demand_pulse_in,
  input wire logic reactive_supply_pulse_in,
  output eim_pkg::eim_totals_t report_totals,
  output logic report_valid,
  output logic report_mega,
  output logic irq
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    EIM_IDLE,
    EIM_ARM,
    EIM_RUN
  } eim_phase_t;

  eim_pkg::eim_cfg_t cfg, next_cfg;
  logic [13:0] ascale, next_ascale;
  logic [13:0] qscale, next_qscale;
  logic [2:0] status, next_status;
  logic [2:0] mask, next_mask;
  eim_pkg::eim_totals_t tot, next_tot;
  eim_pkg::eim_totals_t rep, next_rep;
  logic rep_valid, next_rep_valid;
  logic [5:0] minute, next_minute;
  logic [39:0] tick_cnt, next_tick_cnt;
  eim_phase_t phase, next_phase;
  eim_pkg::eim_pulses_t pulse_q, next_pulse_q;
  logic [31:0] rdata, next_rdata;
  logic rdy, next_rdy;
  logic err, next_err;
  logic irq_q, next_irq_q;

  logic wr_acc;
  logic minute_tick;
  logic boundary;
  logic param_change;
  logic [5:0] per_min;
  logic [3:0] add_en;
  logic [3:0] ovf;
  logic [31:0] add_val [4];
  logic [31:0] cur [4];
  logic [31:0] nxt [4];
  eim_pkg::eim_pulses_t pulses;

  assign pulses = '{active_demand_pulse_in, active_supply_pulse_in,
                    reactive_demand_pulse_in, reactive_supply_pulse_in};
  assign cur[0] = tot.act_dem;
  assign cur[1] = tot.act_sup;
  assign cur[2] = tot.rea_dem;
  assign cur[3] = tot.rea_sup;

  // ==========================================================
  // period length in minutes
  always_comb begin
    case (cfg.period)
      eim_pkg::EIM_PER_5: per_min = 6'h05;
      eim_pkg::EIM_PER_10: per_min = 6'h0A;
      eim_pkg::EIM_PER_15: per_min = 6'h0F;
      eim_pkg::EIM_PER_30: per_min = 6'h1E;
      eim_pkg::EIM_PER_60: per_min = eim_pkg::MIN_PER_HOUR;
      default: per_min = 6'h00;
    endcase
  end

  // ==========================================================
  // real-time clock: minute of the hour
  assign minute_tick = (tick_cnt == 40'(MINUTE_CYCLES - 1));
  always_comb begin
    next_tick_cnt = minute_tick ? 40'h0 : tick_cnt + 40'h1;
    next_minute = minute;
    if (minute_tick) begin
      next_minute = (minute == eim_pkg::MIN_PER_HOUR - 6'h01) ? 6'h00
                    : minute + 6'h01;
    end
  end

  // boundary when the new minute is a multiple of the period
  assign boundary = minute_tick && (per_min != 6'h00) &&
                    ((next_minute % per_min) == 6'h00); // see RL14

  // ==========================================================
  // per-channel increments
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      logic is_p;
      logic want_pos;
      logic [31:0] pw;
      logic [31:0] mag;
      assign is_p = (g < 2);
      assign pw = is_p ? active_power : reactive_power;
      // demand channels take the reference sign, supply the other
      assign want_pos = ((g % 2) == 0) ^ cfg.dir_supply; // see RL5, RL6
      assign mag = pw[31] ? 32'(-pw) : pw;
      always_comb begin
        if (cfg.pulse_src) begin
          // rising edge of the matching pulse input only
          add_en[g] = pulses[3 - g] && !pulse_q[3 - g]; // see RL9, RL12
          add_val[g] = {18'h0, is_p ? ascale : qscale}; // see RL8
        end else begin
          // sign picks exactly one total, never netted
          add_en[g] = power_valid && (pw != 32'h0) &&
                      (pw[31] != want_pos); // see RL7
          add_val[g] = mag;
        end
      end
      assign {ovf[g], nxt[g]} = {1'b0, cur[g]} + {1'b0, add_val[g]};
    end
  endgenerate

  // ==========================================================
  // apb register access
  // decode and read data are formed in the first access cycle; a write
  // lands only at the edge that samples pready high, with the master
  assign wr_acc = psel && penable && pwrite && rdy && !err;

  always_comb begin
    next_cfg = cfg;
    next_ascale = ascale;
    next_qscale = qscale;
    next_mask = mask;
    next_rdata = 32'h0;
    next_err = 1'b0;
    next_rdy = psel && penable && !rdy;
    param_change = 1'b0;
    if (psel && penable) begin
      case (paddr)
        eim_pkg::REG_CTRL: begin
          if (wr_acc) begin
            next_cfg.period = eim_pkg::eim_period_t'(pwdata[2:0]); // see RL1
            next_cfg.pulse_src = pwdata[eim_pkg::CTRL_SRC_BIT]; // see RL2
            next_cfg.cumulate = pwdata[eim_pkg::CTRL_CUM_BIT]; // see RL3
            next_cfg.dir_supply = pwdata[eim_pkg::CTRL_DIR_BIT];
            next_cfg.mega = pwdata[eim_pkg::CTRL_MEGA_BIT]; // see RL10
            // unlisted codes fall back to off
            if (pwdata[2:0] > 3'h5) begin
              next_cfg.period = eim_pkg::EIM_PER_OFF;
            end
          end
          next_rdata = {24'h0, cfg.mega, cfg.dir_supply, cfg.cumulate,
                        cfg.pulse_src, 1'b0, cfg.period};
        end
        eim_pkg::REG_ASCALE, eim_pkg::REG_QSCALE: begin
          if (wr_acc) begin
            // out-of-range weights are clamped, not rejected
            if (paddr == eim_pkg::REG_ASCALE) begin
              next_ascale = clamp(pwdata);
            end else begin
              next_qscale = clamp(pwdata);
            end
          end
          next_rdata = {18'h0, (paddr == eim_pkg::REG_ASCALE) ?
                        ascale : qscale};
        end
        eim_pkg::REG_STATUS: next_rdata = {29'h0, status};
        eim_pkg::REG_MASK: begin
          if (wr_acc) begin
            next_mask = pwdata[2:0];
          end
          next_rdata = {29'h0, mask};
        end
        eim_pkg::REG_ACT_DEM: next_rdata = tot.act_dem;
        eim_pkg::REG_ACT_SUP: next_rdata = tot.act_sup;
        eim_pkg::REG_REA_DEM: next_rdata = tot.rea_dem;
        eim_pkg::REG_REA_SUP: next_rdata = tot.rea_sup;
        eim_pkg::REG_MINUTE: next_rdata = {26'h0, minute};
        eim_pkg::REG_STATE: next_rdata = {30'h0, phase};
        // unmapped: refused once, in the decode cycle
        default: next_err = !rdy;
      endcase
      if (pwrite || rdy) begin
        next_rdata = 32'h0;
      end
    end
    param_change = wr_acc && !next_err &&
                   ({next_cfg, next_ascale, next_qscale} !=
                    {cfg, ascale, qscale});
  end

  function automatic logic [13:0] clamp(input logic [31:0] v);
    if (v < 32'(eim_pkg::SCALE_MIN)) begin
      clamp = eim_pkg::SCALE_MIN;
    end else if (v > 32'(eim_pkg::SCALE_MAX)) begin
      clamp = eim_pkg::SCALE_MAX;
    end else begin
      clamp = v[13:0];
    end
  endfunction

  // ==========================================================
  // interval sequencer and totals
  always_comb begin
    next_phase = phase;
    next_tot = tot;
    next_rep = rep;
    next_rep_valid = 1'b0;
    // sampled every cycle, so an edge seen outside run is never replayed
    next_pulse_q = pulses;
    next_status = status;
    if (wr_acc && paddr == eim_pkg::REG_STATUS) begin
      next_status = status & ~pwdata[2:0];
    end
    case (phase)
      EIM_IDLE: begin
        if (per_min != 6'h00) begin
          next_phase = EIM_ARM;
        end
      end
      EIM_ARM: begin
        if (boundary) begin
          next_phase = EIM_RUN; // see RL16
        end
      end
      EIM_RUN: begin
        next_tot = '{nxt[0], nxt[1], nxt[2], nxt[3]};
        for (int i = 0; i < 4; i++) begin
          if (!add_en[i]) begin
            next_tot[127 - 32*i -: 32] = cur[i];
          end else if (ovf[i]) begin
            next_status[eim_pkg::ST_OVF_BIT] = 1'b1;
          end
        end
        // a parameter change in the same cycle abandons this report
        if (boundary && !param_change) begin
          next_rep = tot; // see RL13
          next_rep_valid = 1'b1;
          next_status[eim_pkg::ST_REPORT_BIT] = 1'b1;
          if (!cfg.cumulate) begin
            // zeroing also drops a sample taken in the boundary cycle
            next_tot = '0; // see RL4
          end
        end
        if (total_clear_input && cfg.cumulate) begin
          next_tot = '0; // see RL11
        end
      end
      default: next_phase = EIM_IDLE;
    endcase
    if (per_min == 6'h00) begin
      next_phase = EIM_IDLE; // see RL17
    end
    if (param_change) begin
      next_tot = '0; // see RL15
      next_phase = EIM_IDLE;
      next_status[eim_pkg::ST_PARAM_BIT] = 1'b1;
    end
    // the mask as it stands after this edge, so irq never lags a write
    next_irq_q = |(next_status & next_mask);
  end

  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{eim_pkg::PER_RESET, eim_pkg::SRC_RESET, eim_pkg::CUM_RESET,
               eim_pkg::DIR_RESET, eim_pkg::MEGA_RESET};
      ascale <= eim_pkg::SCALE_RESET;
      qscale <= eim_pkg::SCALE_RESET;
      status <= 3'h0;
      mask <= 3'h0;
      tot <= '0;
      rep <= '0;
      rep_valid <= 1'b0;
      minute <= 6'h00;
      tick_cnt <= 40'h0;
      phase <= EIM_IDLE;
      pulse_q <= '0;
      rdata <= 32'h0;
      rdy <= 1'b0;
      err <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cfg <= next_cfg;
      ascale <= next_ascale;
      qscale <= next_qscale;
      status <= next_status;
      mask <= next_mask;
      tot <= next_tot;
      rep <= next_rep;
      rep_valid <= next_rep_valid;
      minute <= next_minute;
      tick_cnt <= next_tick_cnt;
      phase <= next_phase;
      pulse_q <= next_pulse_q;
      rdata <= next_rdata;
      rdy <= next_rdy;
      err <= next_err;
      irq_q <= next_irq_q;
    end
  end

  assign prdata = rdata;
  assign pready = rdy;
  assign pslverr = err;
  assign report_totals = rep;
  assign report_valid = rep_valid;
  assign report_mega = cfg.mega;
  assign irq = irq_q;

endmodule

// ---- tb/eim_assertions.sv ----
// port checker for the energy interval meter
`timescale 1ns/10ps
// ==========
// checker
module eim_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire eim_pkg::eim_totals_t report_totals,
  input wire logic report_valid,
  input wire logic report_mega,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property (
    pready && paddr > eim_pkg::REG_STATE |-> pslverr)
    else $error("unmapped address not refused");
  AST_MAPPED_OK: assert property (pready && paddr <= eim_pkg::REG_STATE
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  AST_WRITE_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  AST_REPORT_PULSE: assert property (report_valid |=> !report_valid)
    else $error("report pulse longer than one cycle");
  AST_TOTALS_HOLD: assert property (
    !$stable(report_totals) |-> report_valid)
    else $error("report totals moved without a report");
  AST_MEGA_CFG: assert property (!$stable(report_mega) |->
    $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("unit prefix moved without a write");
  COV_REPORT: cover property (report_valid);
  COV_REFUSED: cover property (pslverr);
  COV_IRQ: cover property ($rose(irq));
  COV_MEGA: cover property (report_valid && report_mega);
endmodule

bind eim_meter eim_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .report_totals(report_totals), .report_valid(report_valid),
  .report_mega(report_mega), .irq(irq));

// ---- tb/eim_pulse_meter.sv ----
// model of the external meter pulse outputs
`timescale 1ns/10ps
// ==========
// pulse meter
module eim_pulse_meter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] fire,
  input wire logic slow,
  output eim_pkg::eim_pulses_t pulses
);
  logic [3:0] q, r, next_q, next_r;
  eim_pkg::eim_pulses_t next_pulses;
  // a slow meter stretches each pulse from two to three cycles
  always_comb begin
    next_q = fire;
    next_r = q & {4{slow}};
    next_pulses = eim_pkg::eim_pulses_t'(fire | q | r);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 4'h0;
      r <= 4'h0;
      pulses <= '0;
    end else begin
      q <= next_q;
      r <= next_r;
      pulses <= next_pulses;
    end
  end
endmodule

// ---- tb/test_energy_interval_metering.sv ----
// self-checking bench of the energy interval meter
`timescale 1ns/10ps
// ==========
// bench
module test_energy_interval_metering;
  localparam int PER = 50; // five minutes of ten cycles
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, a = 32'h0, r = 32'h0;
  logic [31:0] active_power = 32'h0, reactive_power = 32'h0;
  logic pready, pslverr, e, report_valid, report_mega, irq;
  logic power_valid = 0, total_clear_input = 0, slow = 0;
  logic [3:0] fire = 4'h0;
  logic [13:0] aw, qw;
  eim_pkg::eim_pulses_t pl;
  eim_pkg::eim_totals_t report_totals;
  int error_cnt = 0, comparisons = 0, n;

  eim_meter #(.MINUTE_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_power(active_power), .reactive_power(reactive_power),
    .power_valid(power_valid), .total_clear_input(total_clear_input),
    .active_demand_pulse_in(pl.act_dem), .active_supply_pulse_in(pl.act_sup),
    .reactive_demand_pulse_in(pl.rea_dem),
    .reactive_supply_pulse_in(pl.rea_sup), .report_totals(report_totals),
    .report_valid(report_valid), .report_mega(report_mega), .irq(irq));
  eim_pulse_meter u_meter (.pclk(pclk), .presetn(presetn), .fire(fire),
    .slow(slow), .pulses(pl));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task results;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task check(input string nm, input logic [127:0] s, input logic [127:0] x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, x, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_rep(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (report_valid !== 1'b1 && n < lim);
    if (n >= lim) begin
      error_cnt++;
      results();
    end
  endtask

  // channel act_dem gets four pulses, rea_sup one, so swaps show up
  task send;
    for (int k = 0; k < 4; k++) begin
      fire <= 4'hF << k;
      @(posedge pclk);
      fire <= 4'h0;
      repeat (4) @(posedge pclk);
    end
  endtask

  task clear_pulse;
    total_clear_input <= 1'b1;
    @(posedge pclk);
    total_clear_input <= 1'b0;
  endtask

  function automatic eim_pkg::eim_totals_t pexp(input int m);
    return {32'(4 * m * aw), 32'(3 * m * aw), 32'(2 * m * qw), 32'(m * qw)};
  endfunction

  function automatic eim_pkg::eim_totals_t mexp(input logic d);
    logic [31:0] pa, nr;
    pa = 32'(8 * a);
    nr = 32'(8 * (-r));
    return d ? {32'h0, pa, nr, 32'h0} : {pa, 32'h0, 32'h0, nr};
  endfunction

  initial begin
    void'($urandom(17652));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, eim_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", q, 32'h04);
    apb(1'b0, eim_pkg::REG_QSCALE, 32'h0);
    check("qscale reset", q, 32'h64);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", e, 1'b1);
    apb(1'b1, eim_pkg::REG_ASCALE, 32'h0);
    apb(1'b0, eim_pkg::REG_ASCALE, 32'h0);
    check("scale low", q, 32'h1);
    apb(1'b1, eim_pkg::REG_ASCALE, 32'h4E20);
    apb(1'b0, eim_pkg::REG_ASCALE, 32'h0);
    check("scale high", q, 32'h2710);
    aw = 14'($urandom_range(10000, 1));
    qw = 14'($urandom_range(10000, 1));
    apb(1'b1, eim_pkg::REG_ASCALE, 32'(aw));
    apb(1'b1, eim_pkg::REG_QSCALE, 32'(qw));
    apb(1'b1, eim_pkg::REG_MASK, 32'h1);
    for (int d = 0; d < 2; d++) begin
      a = $urandom_range(1000, 1);
      r = -$urandom_range(1000, 1);
      apb(1'b1, eim_pkg::REG_CTRL, (d != 0) ? 32'hC1 : 32'h01);
      wait_rep(200);
      active_power <= a;
      reactive_power <= r;
      power_valid <= 1'b1;
      repeat (8) @(posedge pclk);
      power_valid <= 1'b0;
      send();
      wait_rep(60);
      check("meas totals", report_totals, mexp(d));
      check("mega", report_mega, d);
    end
    apb(1'b0, eim_pkg::REG_STATUS, 32'h0);
    check("irq set", irq, 1'b1);
    apb(1'b1, eim_pkg::REG_STATUS, 32'h7);
    apb(1'b0, eim_pkg::REG_STATUS, 32'h0);
    check("irq clear", irq, 1'b0);
    apb(1'b1, eim_pkg::REG_CTRL, 32'h11);
    wait_rep(200);
    send();
    clear_pulse();
    wait_rep(60);
    check("clear ignored", report_totals, pexp(1));
    send();
    wait_rep(60);
    check("fresh interval", report_totals, pexp(1));
    slow <= 1'b1;
    apb(1'b1, eim_pkg::REG_CTRL, 32'h31);
    wait_rep(200);
    wait_rep(60);
    check("period", n, PER);
    for (int m = 1; m < 3; m++) begin
      send();
      wait_rep(60);
      check("cumulate", report_totals, pexp(m));
    end
    clear_pulse();
    wait_rep(60);
    check("clear", report_totals, pexp(0));
    send();
    apb(1'b1, eim_pkg::REG_CTRL, 32'h30);
    apb(1'b0, eim_pkg::REG_ACT_DEM, 32'h0);
    check("param clear", q, 32'h0);
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      if (report_valid !== 1'b0) n++;
    end
    check("off", n, 0);
    results();
  end
endmodule
